// File: uad_pkg.sv
// Package with constants and types for the USB attach and detach control block.
//==============================================================================
// Functional notes
// - The port works as a full-speed function at 12 Mbit/s with no external transceiver.
// - The port only ever acts as a peripheral and never takes the host role.
// - D+ is pulled up only once software reports that the device is ready to enumerate.
// - The pull-up source is internal or an external resistor on a pin, internal after reset.
// - A pull-up selection value of 16 selects the internal pull-up used when bus powered.
// - When self powered, no pull-up is asserted while the sensed bus power is absent.
// - Bus power is sensed on the pin whose number is in the power sense selection.
// - When self powered, the external pull-up is driven on the pin in the pull-up selection.
// - When bus powered, the reported configuration asks for 100 mA.
// - Host suspend is accepted and a bus-powered device keeps the radio off meanwhile.
// - Detach input and wake output are each mapped to a pin by their own selection.
// - While detach is high, both data lines float and the D+ pull-up is off.
// - When detach falls, the pull-up returns and the device awaits enumeration again.
// - The wake output is active high and is used only while detach is asserted.
// - While detached, no in-band remote wake-up is attempted over the cable.
// - One of two endpoint sets is presented, the standard one or the audio one.
//==============================================================================
package uad_pkg;

  localparam int unsigned GP_PINS = 16;
  localparam int unsigned SEL_W   = 5;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PINSEL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQST  = 8'h0C;
  localparam logic [7:0] OFS_IRQMSK = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;

  // Control bit positions.
  localparam int unsigned CTRL_READY = 0;
  localparam int unsigned CTRL_SELFP = 1;
  localparam int unsigned CTRL_AUDIO = 2;
  localparam int unsigned CTRL_WAKE  = 3;
  localparam int unsigned CTRL_W     = 4;

  // Pin selection field positions.
  localparam int unsigned PS_PULLUP = 0;
  localparam int unsigned PS_SENSE  = 8;
  localparam int unsigned PS_DETACH = 16;
  localparam int unsigned PS_WAKE   = 24;

  // Interrupt bit positions.
  localparam int unsigned IRQ_DET_ON  = 0;
  localparam int unsigned IRQ_DET_OFF = 1;
  localparam int unsigned IRQ_VBUS    = 2;
  localparam int unsigned IRQ_SUSP    = 3;
  localparam int unsigned IRQ_W       = 4;

  // Values after reset.
  localparam logic [CTRL_W-1:0] CTRL_RST     = 4'h0;
  localparam logic [SEL_W-1:0]  SEL_INTERNAL = 5'h10;
  localparam logic [SEL_W-1:0]  SENSE_RST    = 5'h00;
  localparam logic [SEL_W-1:0]  DETACH_RST   = 5'h01;
  localparam logic [SEL_W-1:0]  WAKE_RST     = 5'h02;
  localparam logic [IRQ_W-1:0]  IRQ_RST      = 4'h0;

  // Current request in 2 mA units: 50 units is 100 mA.
  localparam logic [7:0] MAX_POWER_BUS = 8'h32;
  localparam logic [7:0] MAX_POWER_SELF = 8'h00;

  typedef struct packed {
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } uad_apb_rsp_t;

  typedef struct packed {
    logic [GP_PINS-1:0] sync1;
    logic [GP_PINS-1:0] sync2;
    logic [CTRL_W-1:0]  ctrl;
    logic [SEL_W-1:0]   sel_pullup;
    logic [SEL_W-1:0]   sel_sense;
    logic [SEL_W-1:0]   sel_detach;
    logic [SEL_W-1:0]   sel_wake;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic               detach_q;
    logic               vbus_q;
    logic               susp_q;
    logic               attached;
    uad_apb_rsp_t       rsp;
    logic               irq;
    logic [GP_PINS-1:0] pin_out;
    logic [GP_PINS-1:0] pin_oe;
    logic               int_pullup;
    logic               dline_hiz;
    logic               radio_en;
    logic               remote_wake_ok;
    logic               full_speed;
    logic               peripheral_only;
    logic               audio_set;
  } uad_state_t;

endpackage : uad_pkg

// File: uad_attach_ctrl.sv
// USB attach, detach, pull-up and wake control with an APB register file.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module uad_attach_ctrl
  import uad_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [GP_PINS-1:0] gp_pin_in,
  output logic [GP_PINS-1:0]      gp_pin_out,
  output logic [GP_PINS-1:0]      gp_pin_oe,
  input  wire logic               usb_suspend,
  output logic                    usb_dplus_line_pullup,
  output logic                    usb_lines_hiz,
  output logic                    radio_enable,
  output logic                    remote_wake_allow,
  output logic                    full_speed_mode,
  output logic                    peripheral_mode,
  output logic                    audio_endpoints,
  output logic                    irq
);

  //============================================================================
  // Helpers
  //============================================================================

  // Out-of-range pin numbers read as low so a bad selection cannot assert anything.
  function automatic logic pick_pin(input logic [GP_PINS-1:0] v, input logic [SEL_W-1:0] s);
    logic r;
    r = 1'b0;
    if (s < SEL_W'(GP_PINS)) begin
      r = v[s[3:0]];
    end
    return r;
  endfunction : pick_pin

  function automatic logic [GP_PINS-1:0] one_hot(input logic [SEL_W-1:0] s);
    logic [GP_PINS-1:0] r;
    r = '0;
    if (s < SEL_W'(GP_PINS)) begin
      r[s[3:0]] = 1'b1;
    end
    return r;
  endfunction : one_hot

  //============================================================================
  // State
  //============================================================================

  uad_state_t st_ff;
  uad_state_t nxt_st;

  logic       detach_now;
  logic       vbus_now;
  logic       self_pwr;
  logic       pull_on;
  logic       use_int;
  logic       wake_drive;
  logic       acc_done;
  logic       wr_en;
  logic [31:0] rd_word;
  logic       addr_ok;

  always_comb begin
    nxt_st = st_ff;

    // Pins pass two flops before any selection logic looks at them.
    nxt_st.sync1 = gp_pin_in;
    nxt_st.sync2 = st_ff.sync1;

    detach_now = pick_pin(st_ff.sync2, st_ff.sel_detach);
    vbus_now   = pick_pin(st_ff.sync2, st_ff.sel_sense);
    self_pwr   = st_ff.ctrl[CTRL_SELFP];
    use_int    = (st_ff.sel_pullup == SEL_INTERNAL);

    // Pull-up only when software is ready, not detached, and bus power is present
    // in self-powered mode. Bus-powered parts are running from VBUS so it is present.
    pull_on = st_ff.ctrl[CTRL_READY] && !detach_now && (!self_pwr || vbus_now);

    //==========================================================================
    // Link outputs
    //==========================================================================
    nxt_st.int_pullup = pull_on && use_int;
    nxt_st.dline_hiz  = detach_now || !pull_on;
    nxt_st.attached   = pull_on;
    nxt_st.full_speed = 1'b1;
    nxt_st.peripheral_only = 1'b1;
    nxt_st.audio_set  = st_ff.ctrl[CTRL_AUDIO];
    // Bus-powered parts may not draw radio current while suspended.
    nxt_st.radio_en   = !(usb_suspend && !self_pwr);
    nxt_st.remote_wake_ok = pull_on && usb_suspend;

    wake_drive = st_ff.ctrl[CTRL_WAKE] && detach_now;
    nxt_st.pin_out = '0;
    nxt_st.pin_oe  = '0;
    // The external resistor pin floats when off, so it never pulls D+ down.
    if (!use_int && pull_on) begin
      nxt_st.pin_out = one_hot(st_ff.sel_pullup);
      nxt_st.pin_oe  = one_hot(st_ff.sel_pullup);
    end
    if (st_ff.sel_wake != st_ff.sel_pullup || use_int) begin
      nxt_st.pin_oe  = nxt_st.pin_oe | one_hot(st_ff.sel_wake);
      if (wake_drive) begin
        nxt_st.pin_out = nxt_st.pin_out | one_hot(st_ff.sel_wake);
      end
    end

    //==========================================================================
    // Events
    //==========================================================================
    nxt_st.detach_q = detach_now;
    nxt_st.vbus_q   = vbus_now;
    nxt_st.susp_q   = usb_suspend;

    //==========================================================================
    // APB slave: one wait state, write and read data at the edge with pready.
    //==========================================================================
    unique case (paddr)
      OFS_CTRL, OFS_PINSEL, OFS_STATUS, OFS_IRQST, OFS_IRQMSK, OFS_CONFIG: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase

    rd_word = '0;
    unique case (paddr)
      OFS_CTRL: begin
        rd_word[CTRL_W-1:0] = st_ff.ctrl;
      end
      OFS_PINSEL: begin
        rd_word[PS_PULLUP +: SEL_W] = st_ff.sel_pullup;
        rd_word[PS_SENSE  +: SEL_W] = st_ff.sel_sense;
        rd_word[PS_DETACH +: SEL_W] = st_ff.sel_detach;
        rd_word[PS_WAKE   +: SEL_W] = st_ff.sel_wake;
      end
      OFS_STATUS: begin
        rd_word[0] = st_ff.attached;
        rd_word[1] = st_ff.detach_q;
        rd_word[2] = st_ff.vbus_q;
        rd_word[3] = st_ff.susp_q;
        rd_word[4] = st_ff.int_pullup;
        rd_word[5] = st_ff.radio_en;
      end
      OFS_IRQST: begin
        rd_word[IRQ_W-1:0] = st_ff.irq_stat;
      end
      OFS_IRQMSK: begin
        rd_word[IRQ_W-1:0] = st_ff.irq_mask;
      end
      OFS_CONFIG: begin
        rd_word[7:0] = self_pwr ? MAX_POWER_SELF : MAX_POWER_BUS;
      end
      default: begin
        rd_word = '0;
      end
    endcase

    acc_done = psel && penable && st_ff.rsp.pready;
    wr_en    = acc_done && pwrite && addr_ok;
    nxt_st.rsp.pready  = psel && penable && !st_ff.rsp.pready;
    nxt_st.rsp.pslverr = psel && penable && !st_ff.rsp.pready && !addr_ok;
    if (psel && penable && !st_ff.rsp.pready && !pwrite) begin
      nxt_st.rsp.prdata = rd_word;
    end

    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          nxt_st.ctrl = pwdata[CTRL_W-1:0];
        end
        OFS_PINSEL: begin
          nxt_st.sel_pullup = pwdata[PS_PULLUP +: SEL_W];
          nxt_st.sel_sense  = pwdata[PS_SENSE  +: SEL_W];
          nxt_st.sel_detach = pwdata[PS_DETACH +: SEL_W];
          nxt_st.sel_wake   = pwdata[PS_WAKE   +: SEL_W];
        end
        OFS_IRQMSK: begin
          nxt_st.irq_mask = pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Write-one clears first, then new events set, so a coinciding event wins.
    if (wr_en && paddr == OFS_IRQST) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    if (detach_now && !st_ff.detach_q) begin
      nxt_st.irq_stat[IRQ_DET_ON] = 1'b1;
    end
    if (!detach_now && st_ff.detach_q) begin
      nxt_st.irq_stat[IRQ_DET_OFF] = 1'b1;
    end
    if (vbus_now != st_ff.vbus_q) begin
      nxt_st.irq_stat[IRQ_VBUS] = 1'b1;
    end
    if (usb_suspend && !st_ff.susp_q) begin
      nxt_st.irq_stat[IRQ_SUSP] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff                 <= '0;
      st_ff.ctrl            <= CTRL_RST;
      st_ff.sel_pullup      <= SEL_INTERNAL;
      st_ff.sel_sense       <= SENSE_RST;
      st_ff.sel_detach      <= DETACH_RST;
      st_ff.sel_wake        <= WAKE_RST;
      st_ff.irq_stat        <= IRQ_RST;
      st_ff.irq_mask        <= IRQ_RST;
      st_ff.dline_hiz       <= 1'b1;
      st_ff.radio_en        <= 1'b1;
      st_ff.full_speed      <= 1'b1;
      st_ff.peripheral_only <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //============================================================================
  // Outputs
  //============================================================================
  assign prdata                = st_ff.rsp.prdata;
  assign pready                = st_ff.rsp.pready;
  assign pslverr               = st_ff.rsp.pslverr;
  assign gp_pin_out            = st_ff.pin_out;
  assign gp_pin_oe             = st_ff.pin_oe;
  assign usb_dplus_line_pullup = st_ff.int_pullup;
  assign usb_lines_hiz         = st_ff.dline_hiz;
  assign radio_enable          = st_ff.radio_en;
  assign remote_wake_allow     = st_ff.remote_wake_ok;
  assign full_speed_mode       = st_ff.full_speed;
  assign peripheral_mode       = st_ff.peripheral_only;
  assign audio_endpoints       = st_ff.audio_set;
  assign irq                   = st_ff.irq;

endmodule : uad_attach_ctrl

`default_nettype wire

// File: uad_attach_checker.sv
// Assertion checker for the USB attach and detach control block.
`timescale 1ns/1ps
`default_nettype none
module uad_attach_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] gp_pin_in,
  input wire logic [15:0] gp_pin_out,
  input wire logic [15:0] gp_pin_oe,
  input wire logic        usb_suspend,
  input wire logic        usb_dplus_line_pullup,
  input wire logic        usb_lines_hiz,
  input wire logic        radio_enable,
  input wire logic        remote_wake_allow,
  input wire logic        full_speed_mode,
  input wire logic        peripheral_mode,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  //============================================================
  // Properties
  // Pin checks assume the default detach pin 1 and wake pin 2.
  apb_answer_a: assert property (psel && penable && !pready |=> pready && !$past(pready))
    else $error("pready did not follow the access phase");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  fixed_modes_a: assert property (full_speed_mode && peripheral_mode)
    else $error("speed or role mode lost");
  detach_float_a: assert property ($past(gp_pin_in[1], 3) |-> usb_lines_hiz && !usb_dplus_line_pullup)
    else $error("lines driven while detached");
  wake_only_det_a: assert property (gp_pin_out[2] |-> $past(gp_pin_in[1], 3))
    else $error("wake output without detach");
  sync_delay_a: assert property ($rose(gp_pin_in[1]) |=> $stable(usb_lines_hiz)[*2])
    else $error("detach acted on too early");
  radio_susp_a: assert property (!radio_enable |-> usb_suspend || $past(usb_suspend)
    || $past(usb_suspend, 2))
    else $error("radio off without suspend");
  wake_pin_oe_a: assert property (!$past(reset) |-> gp_pin_oe[2])
    else $error("wake pin not driven");
  no_inband_a: assert property ($past(gp_pin_in[1], 3) && $past(gp_pin_in[1], 4)
    && $past(gp_pin_in[1], 5) |-> !remote_wake_allow)
    else $error("in-band wake allowed while detached");
  cov_detach: cover property (usb_lines_hiz && $past(usb_dplus_line_pullup));
  cov_irq: cover property (irq);
  cov_rwake: cover property (remote_wake_allow);
  cov_slverr: cover property (pslverr);
endmodule : uad_attach_checker
bind uad_attach_ctrl uad_attach_checker u_uad_attach_checker (.ref_clk, .reset, .psel,
  .penable, .pready, .pslverr, .gp_pin_in, .gp_pin_out, .gp_pin_oe, .usb_suspend,
  .usb_dplus_line_pullup, .usb_lines_hiz, .radio_enable, .remote_wake_allow,
  .full_speed_mode, .peripheral_mode, .irq);
`default_nettype wire

// File: uad_host_model.sv
// Host side model that enumerates an attached port and may suspend it.
`timescale 1ns/1ps
`default_nettype none
module uad_host_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic dplus_high,
  input  wire logic suspend_req,
  output logic      usb_suspend
);
  //============================================================
  // Enumeration
  // A port is suspended only after it has stayed attached a while.
  logic [3:0] seen_ff;
  logic       susp_ff;
  always_ff @(posedge ref_clk) begin
    if (reset || !dplus_high) begin
      seen_ff <= 4'h0;
      susp_ff <= 1'b0;
    end else begin
      seen_ff <= (seen_ff == 4'hf) ? seen_ff : seen_ff + 4'h1;
      susp_ff <= suspend_req && (seen_ff == 4'hf);
    end
  end
  assign usb_suspend = susp_ff;
endmodule : uad_host_model
`default_nettype wire

// File: tb.sv
// Testbench for the USB attach and detach control block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import uad_pkg::*;
;
  logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic        pready, pslverr, rerr, suspend_req = 1'b0, usb_suspend;
  logic [15:0] gp_pin_in = 16'h0000, gp_pin_out, gp_pin_oe;
  logic        usb_dplus_line_pullup, usb_lines_hiz, radio_enable, remote_wake_allow;
  logic        full_speed_mode, peripheral_mode, audio_endpoints, irq;
  int          err_total = 0, checked = 0;
  wire logic [7:0] outs = {irq, audio_endpoints, peripheral_mode, full_speed_mode,
    remote_wake_allow, radio_enable, usb_lines_hiz, usb_dplus_line_pullup};
  always #5 ref_clk = ~ref_clk;
  uad_attach_ctrl u_uad_attach_ctrl (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .gp_pin_in, .gp_pin_out, .gp_pin_oe, .usb_suspend,
    .usb_dplus_line_pullup, .usb_lines_hiz, .radio_enable, .remote_wake_allow,
    .full_speed_mode, .peripheral_mode, .audio_endpoints, .irq);
  uad_host_model u_uad_host_model (.ref_clk, .reset, .suspend_req, .usb_suspend,
    .dplus_high(usb_dplus_line_pullup | (gp_pin_oe[5] & gp_pin_out[5])));
  //============================================================
  // Tasks
  task automatic stop_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ochk(input logic [7:0] exp);
    chk({24'h0, outs}, {24'h0, exp});
  endtask : ochk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rchk
  // Pins pass two sync flops and an output flop; four edges cover that.
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic setpin(input int i, input logic v);
    @(posedge ref_clk);
    gp_pin_in[i] <= v;
    settle();
  endtask : setpin
  //============================================================
  // Tests
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    ochk(8'h36);
    rchk(OFS_CTRL, 32'h0000_0000);
    rchk(OFS_PINSEL, 32'h0201_0010);
    rchk(OFS_CONFIG, 32'h0000_0032);
    rchk(8'h18, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    apb(1'b1, OFS_IRQMSK, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    settle();
    ochk(8'h35);
    setpin(1, 1'b1);
    ochk(8'hb6);
    chk({31'h0, gp_pin_out[2]}, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0009);
    settle();
    chk({31'h0, gp_pin_out[2]}, 32'h0000_0001);
    rchk(OFS_IRQST, 32'h0000_0001);
    apb(1'b1, OFS_IRQST, 32'h0000_0001);
    settle();
    ochk(8'h36);
    setpin(1, 1'b0);
    ochk(8'hb5);
    chk({31'h0, gp_pin_out[2]}, 32'h0000_0000);
    apb(1'b1, OFS_IRQST, 32'h0000_0003);
    suspend_req <= 1'b1;
    // The host only suspends a port that has stayed attached for sixteen edges.
    repeat (4) settle();
    ochk(8'h39);
    rchk(OFS_IRQST, 32'h0000_0008);
    setpin(1, 1'b1);
    settle();
    ochk(8'hb6);
    @(posedge ref_clk);
    suspend_req <= 1'b0;
    setpin(1, 1'b0);
    apb(1'b1, OFS_IRQST, 32'h0000_000f);
    apb(1'b1, OFS_PINSEL, 32'h0201_0005);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    settle();
    chk({29'h0, gp_pin_oe[5], usb_dplus_line_pullup, audio_endpoints}, 32'h1);
    rchk(OFS_CONFIG, 32'h0000_0000);
    setpin(0, 1'b1);
    chk({29'h0, gp_pin_oe[5], gp_pin_out[5], usb_dplus_line_pullup}, 32'h6);
    rchk(OFS_STATUS, 32'h0000_0025);
    apb(1'b1, OFS_PINSEL, 32'h0201_0305);
    settle();
    chk({31'h0, gp_pin_oe[5]}, 32'h0000_0000);
    rchk(OFS_IRQST, 32'h0000_0004);
    stop_test();
  end
endmodule : tb
`default_nettype wire
